// ### verilog/accel_pkg.sv
// What this block does
// - divisor write starts division, sets busy
// - finish clears busy, stores quotient, remainder
// - busy blocks control, operand register writes
// - fast-bus result reads stall until done
// - local port never waits
// - local port user polls busy first
// - signed mode: remainder follows numerator sign
// - short signed results sign-extended to 32
// - most negative by minus one wraps
// - zero divisor: quotient 0, remainder numerator
// - zero flag clears only by writing one or by reset
// - leading skip on after reset, bit disables
// - skip on: 2-8 or 2-16 cycles
// - skip off: fixed 8 or 16 cycles
// - root operand write starts square root
// - set control before start, hold while busy
// - numerator first, divisor write last
// - engine clock enabled before any access
// - both paths see one register set
package accel_pkg;
  // ****************************************
  // engine register map (byte offsets)
  // ****************************************
  localparam logic [7:0] OFS_CONTROL   = 8'h00; // control_word
  localparam logic [7:0] OFS_STATUS    = 8'h04; // busy, zero flag
  localparam logic [7:0] OFS_NUMERATOR = 8'h08;
  localparam logic [7:0] OFS_DIVISOR   = 8'h0C;
  localparam logic [7:0] OFS_RESULT    = 8'h10;
  localparam logic [7:0] OFS_REMAINDER = 8'h14;
  localparam logic [7:0] OFS_ROOT      = 8'h18;
  // field positions
  localparam int BIT_SIGNED    = 0; // control_word
  localparam int BIT_SKIP_OFF  = 1; // control_word
  localparam int BIT_BUSY      = 0; // status
  localparam int BIT_DIV_ZERO  = 1; // status
  localparam logic [1:0] CONTROL_RESET = 2'h0; // skip enabled
  // cycle counts
  localparam logic [4:0] CYC_LONG  = 5'h10; // 32-bit, fixed
  localparam logic [4:0] CYC_SHORT = 5'h08; // 16-bit, fixed
  localparam logic [4:0] CYC_MIN   = 5'h02;
  localparam logic [4:0] CYC_ROOT  = 5'h10;
  // ****************************************
  // controller command registers
  // ****************************************
  localparam logic [7:0] CMD_SETUP  = 8'h00;
  localparam logic [7:0] CMD_OPA    = 8'h04;
  localparam logic [7:0] CMD_OPB    = 8'h08;
  localparam logic [7:0] CMD_GO     = 8'h0C;
  localparam logic [7:0] CMD_STATUS = 8'h10;
  localparam logic [7:0] CMD_RESULT = 8'h14;
  localparam logic [7:0] CMD_REMAIN = 8'h18;
  localparam int SET_SIGNED  = 0;
  localparam int SET_SKIPOFF = 1;
  localparam int SET_FAST    = 2; // use fast bus path
  localparam int SET_ROOT    = 3; // square root job
  localparam int SET_CLKON   = 4; // request engine clock
  // ****************************************
  // state encodings
  // ****************************************
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_DIV  = 2'b01,
    ENG_ROOT = 2'b10
  } eng_state_e;
  typedef enum logic [1:0] {
    CTL_IDLE  = 2'b00,
    CTL_ISSUE = 2'b01,
    CTL_WAIT  = 2'b10
  } ctl_state_e;
endpackage : accel_pkg

// ### verilog/accel_if.sv
`timescale 1ns/1ps
interface accel_if;
  // fast bus: request held until ready pulse
  logic        hs_req;
  logic        hs_we;
  logic [7:0]  hs_addr;
  logic [31:0] hs_wdata;
  logic        hs_ready;
  logic [31:0] hs_rdata;
  // local port: one-cycle strobes, data next cycle
  logic        lp_write;
  logic        lp_read;
  logic [7:0]  lp_addr;
  logic [31:0] lp_wdata;
  logic [31:0] lp_rdata;
  modport engine (input hs_req, hs_we, hs_addr, hs_wdata, output hs_ready, hs_rdata,
                  input lp_write, lp_read, lp_addr, lp_wdata, output lp_rdata);
  modport cpu (output hs_req, hs_we, hs_addr, hs_wdata, input hs_ready, hs_rdata,
               output lp_write, lp_read, lp_addr, lp_wdata, input lp_rdata);
endinterface : accel_if

// ### verilog/div_root_engine.sv
`timescale 1ns/1ps
module div_root_engine
  import accel_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // both access paths
  accel_if.engine  bus
);
  // ****************************************
  // helper functions
  // ****************************************
  // value fits 16 bits for the chosen signedness
  function automatic logic fits16(input logic [31:0] v, input logic sgn);
    fits16 = sgn ? (v[31:15] == 17'h00000 || v[31:15] == 17'h1FFFF) : (v[31:16] == 16'h0000);
  endfunction : fits16
  // magnitude in signed mode, raw otherwise
  function automatic logic [31:0] mag(input logic [31:0] v, input logic sgn);
    mag = (sgn && v[31]) ? (32'h0 - v) : v;
  endfunction : mag
  // count of significant bits
  function automatic logic [5:0] sig_bits(input logic [31:0] v);
    sig_bits = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        sig_bits = 6'(i + 1);
      end
    end
  endfunction : sig_bits

  // ****************************************
  // registers
  // ****************************************
  logic [1:0]  control_word;   // signed, skip-disable
  logic        busy;           // operation running
  logic        div_zero_flag;  // sticky zero divisor
  logic [31:0] numerator_in;
  logic [31:0] divisor_in;
  logic [31:0] root_operand;
  logic [31:0] result_out;
  logic [31:0] remainder_out;
  eng_state_e  state;
  logic [4:0]  cnt;            // remaining cycles
  logic [33:0] acc;            // partial remainder
  logic [31:0] sh;             // operand / quotient shifter
  logic [15:0] root;           // partial root
  logic [31:0] dv_mag;         // divisor magnitude
  logic        neg_q;          // negate quotient
  logic        neg_r;          // negate remainder
  logic        short_q;        // signed 16-bit run: sign-extend from bit 15
  logic        hs_ready;
  logic [31:0] hs_rdata;
  logic [31:0] lp_rdata;

  // ****************************************
  // write path selection
  // ****************************************
  wire        hs_pend   = bus.hs_req && !hs_ready;
  wire        hs_is_res = (bus.hs_addr == OFS_RESULT) || (bus.hs_addr == OFS_REMAINDER);
  // result reads wait for the engine; the local port never does
  wire        hs_stall  = (!bus.hs_we && hs_is_res && busy)
                          || (bus.hs_we && bus.lp_write);   // local write owns this cycle
  wire        hs_take   = hs_pend && !hs_stall;
  wire        hs_wr     = hs_take && bus.hs_we;
  // one write port feeds the shared register set
  wire        wr_en     = bus.lp_write || hs_wr;
  wire [7:0]  wr_addr   = bus.lp_write ? bus.lp_addr : bus.hs_addr;
  wire [31:0] wr_data   = bus.lp_write ? bus.lp_wdata : bus.hs_wdata;
  wire        wr_open   = wr_en && !busy;
  wire        start_div = wr_open && (wr_addr == OFS_DIVISOR);
  wire        start_rt  = wr_open && (wr_addr == OFS_ROOT);
  wire        clr_zero  = wr_en && (wr_addr == OFS_STATUS) && wr_data[BIT_DIV_ZERO];

  // ****************************************
  // division setup
  // ****************************************
  wire        sgn     = control_word[BIT_SIGNED];
  wire [31:0] n_mag   = mag(numerator_in, sgn);
  wire [31:0] d_mag   = mag(wr_data, sgn);
  wire        short_op = fits16(numerator_in, sgn) && fits16(wr_data, sgn);
  wire [4:0]  fixed   = short_op ? CYC_SHORT : CYC_LONG;
  wire [5:0]  nbits   = sig_bits(n_mag);
  wire [4:0]  half    = 5'((nbits + 6'd1) >> 1);
  // skipping trades fixed latency for speed on small numerators
  wire [4:0]  skip    = (half < CYC_MIN) ? CYC_MIN : half;
  wire [4:0]  first   = control_word[BIT_SKIP_OFF] ? fixed : skip;
  wire [31:0] sh_init = n_mag << (6'd32 - {first, 1'b0});

  // ****************************************
  // two restoring steps per cycle
  // ****************************************
  wire [32:0] r1   = {acc[31:0], sh[31]};
  wire        ge1  = r1 >= {1'b0, dv_mag};
  wire [32:0] r1b  = ge1 ? (r1 - {1'b0, dv_mag}) : r1;
  wire [32:0] r2   = {r1b[31:0], sh[30]};
  wire        ge2  = r2 >= {1'b0, dv_mag};
  wire [32:0] r2b  = ge2 ? (r2 - {1'b0, dv_mag}) : r2;
  wire [31:0] q_nx = {sh[29:0], ge1, ge2};
  wire [31:0] q_fin = neg_q ? (32'h0 - q_nx) : q_nx;
  wire [31:0] r_fin = neg_r ? (32'h0 - r2b[31:0]) : r2b[31:0];

  // ****************************************
  // one root digit per cycle
  // ****************************************
  wire [33:0] ra    = {acc[31:0], sh[31:30]};
  wire [33:0] rt    = {16'h0000, root, 2'b01};
  wire        rge   = ra >= rt;
  wire [33:0] ra_nx = rge ? (ra - rt) : ra;
  wire [15:0] rt_nx = {root[14:0], rge};
  wire        last  = (cnt == 5'h01);

  // ****************************************
  // read decode shared by both paths
  // ****************************************
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    unique case (a)
      OFS_CONTROL:   rd_mux = {30'h0, control_word};
      OFS_STATUS:    rd_mux = {30'h0, div_zero_flag, busy};
      OFS_NUMERATOR: rd_mux = numerator_in;
      OFS_DIVISOR:   rd_mux = divisor_in;
      OFS_RESULT:    rd_mux = result_out;
      OFS_REMAINDER: rd_mux = remainder_out;
      OFS_ROOT:      rd_mux = root_operand;
      default:       rd_mux = 32'h00000000; // unmapped reads zero
    endcase
  endfunction : rd_mux

  // ****************************************
  // configuration and operand registers
  // ****************************************
  // writes while busy are dropped silently
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      control_word <= CONTROL_RESET;
      numerator_in <= 32'h00000000;
      divisor_in   <= 32'h00000000;
      root_operand <= 32'h00000000;
    end else if (wr_open) begin
      if (wr_addr == OFS_CONTROL)   control_word <= wr_data[1:0];
      if (wr_addr == OFS_NUMERATOR) numerator_in <= wr_data;
      if (wr_addr == OFS_DIVISOR)   divisor_in   <= wr_data;
      if (wr_addr == OFS_ROOT)      root_operand <= wr_data;
    end
  end

  // ****************************************
  // zero-divisor flag
  // ****************************************
  // a fresh fault beats a clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_zero_flag <= 1'b0;
    end else if (start_div && wr_data == 32'h0) begin
      div_zero_flag <= 1'b1;
    end else if (clr_zero) begin
      div_zero_flag <= 1'b0;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= ENG_IDLE;
      busy  <= 1'b0;
      cnt   <= 5'h00;
      acc   <= 34'h0;
      sh    <= 32'h0;
      root  <= 16'h0;
      dv_mag <= 32'h0;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
      short_q <= 1'b0;
      result_out    <= 32'h0;
      remainder_out <= 32'h0;
    end else begin
      unique case (state)
        ENG_IDLE: begin
          if (start_div) begin
            state  <= ENG_DIV;
            busy   <= 1'b1;
            cnt    <= first;
            acc    <= 34'h0;
            sh     <= sh_init;
            dv_mag <= d_mag;
            neg_q  <= sgn && (numerator_in[31] ^ wr_data[31]);
            neg_r  <= sgn && numerator_in[31];
            short_q <= sgn && short_op;
          end else if (start_rt) begin
            state <= ENG_ROOT;
            busy  <= 1'b1;
            cnt   <= CYC_ROOT;
            acc   <= 34'h0;
            sh    <= wr_data;
            root  <= 16'h0;
          end
        end
        ENG_DIV: begin
          acc <= {1'b0, r2b};
          sh  <= q_nx;
          cnt <= cnt - 5'h01;
          if (last) begin
            state <= ENG_IDLE;
            busy  <= 1'b0;
            if (divisor_in == 32'h0) begin
              result_out    <= 32'h0;
              remainder_out <= numerator_in;
            end else begin
              // a short signed run wraps at 16 bits, so 8000 by -1 stays most negative
              result_out    <= short_q ? {{16{q_fin[15]}}, q_fin[15:0]} : q_fin;
              remainder_out <= r_fin;
            end
          end
        end
        ENG_ROOT: begin
          acc  <= ra_nx;
          sh   <= {sh[29:0], 2'b00};
          root <= rt_nx;
          cnt  <= cnt - 5'h01;
          if (last) begin
            state         <= ENG_IDLE;
            busy          <= 1'b0;
            result_out    <= {16'h0000, rt_nx};
            remainder_out <= ra_nx[31:0];
          end
        end
        default: state <= ENG_IDLE;
      endcase
    end
  end

  // ****************************************
  // bus answers
  // ****************************************
  // local port answers every read the next cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lp_rdata <= 32'h0;
      hs_ready <= 1'b0;
      hs_rdata <= 32'h0;
    end else begin
      if (bus.lp_read) lp_rdata <= rd_mux(bus.lp_addr);
      hs_ready <= hs_take;
      if (hs_take && !bus.hs_we) hs_rdata <= rd_mux(bus.hs_addr);
    end
  end

  assign bus.lp_rdata = lp_rdata;
  assign bus.hs_ready = hs_ready;
  assign bus.hs_rdata = hs_rdata;
endmodule : div_root_engine

// ### verilog/accel_master.sv
`timescale 1ns/1ps
module accel_master
  import accel_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // command port
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic        cmd_write,
  input  wire logic        cmd_read,
  output logic      [31:0] cmd_rdata,
  // power manager request
  output logic             clk_req,
  // engine side
  accel_if.cpu             bus
);
  // ****************************************
  // registers
  // ****************************************
  logic [4:0]  setup;     // job options
  logic [31:0] opa;       // numerator or root operand
  logic [31:0] opb;       // divisor
  logic [31:0] res;
  logic [31:0] rem;
  logic        running;
  logic        done;
  logic        zero;      // captured zero flag
  ctl_state_e  state;
  logic [2:0]  step;      // 0 ctrl,1 num,2 start,3 poll,4 res,5 rem,6 status
  logic        hs_req;
  logic        hs_we;
  logic        lp_write;
  logic        lp_read;
  logic [7:0]  addr;
  logic [31:0] wdata;

  // ****************************************
  // step decode
  // ****************************************
  wire        fast   = setup[SET_FAST];
  wire        is_rt  = setup[SET_ROOT];
  wire        go     = cmd_write && cmd_addr == CMD_GO && !running && setup[SET_CLKON];
  wire [7:0]  st_addr = (step == 3'd0) ? OFS_CONTROL :
                        (step == 3'd1) ? OFS_NUMERATOR :
                        (step == 3'd2) ? (is_rt ? OFS_ROOT : OFS_DIVISOR) :
                        (step == 3'd4) ? OFS_RESULT :
                        (step == 3'd5) ? OFS_REMAINDER : OFS_STATUS;
  wire [31:0] st_data = (step == 3'd0) ? {30'h0, setup[SET_SKIPOFF], setup[SET_SIGNED]} :
                        (step == 3'd1) ? opa :
                        (is_rt ? opa : opb);
  wire        st_we   = step < 3'd3;
  wire        ack     = fast ? bus.hs_ready : 1'b1;
  wire [31:0] rdv     = fast ? bus.hs_rdata : bus.lp_rdata;
  // fast path reads results straight away, waits absorb the run
  wire [2:0]  after2  = fast ? 3'd4 : 3'd3;
  wire [2:0]  after0  = is_rt ? 3'd2 : 3'd1;
  wire [2:0]  nx_step = (step == 3'd0) ? after0 :
                        (step == 3'd2) ? after2 :
                        (step == 3'd3) ? (rdv[BIT_BUSY] ? 3'd3 : 3'd4) :
                        3'(step + 3'd1);

  // ****************************************
  // command registers
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      setup <= 5'h00;
      opa   <= 32'h0;
      opb   <= 32'h0;
      clk_req <= 1'b0;
    end else begin
      // options frozen while a job runs
      if (cmd_write && !running) begin
        if (cmd_addr == CMD_SETUP) setup <= cmd_wdata[4:0];
        if (cmd_addr == CMD_OPA)   opa   <= cmd_wdata;
        if (cmd_addr == CMD_OPB)   opb   <= cmd_wdata;
      end
      clk_req <= setup[SET_CLKON];
    end
  end

  // command readback, one cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_rdata <= 32'h0;
    end else if (cmd_read) begin
      unique case (cmd_addr)
        CMD_SETUP:  cmd_rdata <= {27'h0, setup};
        CMD_OPA:    cmd_rdata <= opa;
        CMD_OPB:    cmd_rdata <= opb;
        CMD_STATUS: cmd_rdata <= {29'h0, zero, done, running};
        CMD_RESULT: cmd_rdata <= res;
        CMD_REMAIN: cmd_rdata <= rem;
        default:    cmd_rdata <= 32'h0;
      endcase
    end
  end

  // ****************************************
  // access sequencer
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= CTL_IDLE;
      step  <= 3'd0;
      running <= 1'b0;
      done  <= 1'b0;
      zero  <= 1'b0;
      res   <= 32'h0;
      rem   <= 32'h0;
      hs_req <= 1'b0;
      hs_we <= 1'b0;
      lp_write <= 1'b0;
      lp_read <= 1'b0;
      addr  <= 8'h00;
      wdata <= 32'h0;
    end else begin
      lp_write <= 1'b0;
      lp_read  <= 1'b0;
      unique case (state)
        CTL_IDLE: begin
          if (go) begin
            running <= 1'b1;
            done    <= 1'b0;
            step    <= 3'd0;
            state   <= CTL_ISSUE;
          end
        end
        CTL_ISSUE: begin
          addr  <= st_addr;
          wdata <= st_data;
          hs_we <= st_we;
          if (fast) hs_req <= 1'b1;
          else begin
            lp_write <= st_we;
            lp_read  <= !st_we;
          end
          state <= CTL_WAIT;
        end
        CTL_WAIT: begin
          // local port: data stands one cycle after the strobe
          if (!fast && (lp_write || lp_read)) begin
            state <= CTL_WAIT;
          end else if (ack) begin
            hs_req <= 1'b0;
            if (step == 3'd4) res <= rdv;
            if (step == 3'd5) rem <= rdv;
            if (step == 3'd6) begin
              zero    <= rdv[BIT_DIV_ZERO];
              running <= 1'b0;
              done    <= 1'b1;
              state   <= CTL_IDLE;
            end else begin
              step  <= nx_step;
              state <= CTL_ISSUE;
            end
          end
        end
        default: state <= CTL_IDLE;
      endcase
    end
  end

  assign bus.hs_req   = hs_req;
  assign bus.hs_we    = hs_we;
  assign bus.hs_addr  = addr;
  assign bus.hs_wdata = wdata;
  assign bus.lp_write = lp_write;
  assign bus.lp_read  = lp_read;
  assign bus.lp_addr  = addr;
  assign bus.lp_wdata = wdata;
endmodule : accel_master

// ### tb/accel_monitor.sv
`timescale 1ns/1ps
// ****************************************
// interface watcher between master and engine
// ****************************************
module accel_monitor
  import accel_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // fast bus
  input wire logic        hs_req,
  input wire logic        hs_we,
  input wire logic [7:0]  hs_addr,
  input wire logic [31:0] hs_wdata,
  input wire logic        hs_ready,
  input wire logic [31:0] hs_rdata,
  // local port
  input wire logic        lp_write,
  input wire logic        lp_read,
  input wire logic [7:0]  lp_addr,
  input wire logic [31:0] lp_wdata,
  input wire logic [31:0] lp_rdata
);
  logic       wr_ev;   // a write lands on either path
  logic [7:0] wr_addr; // its target
  logic [7:0] last_wr; // previous write target
  logic [7:0] last_rd; // previous local read target
  assign wr_ev   = lp_write | (hs_ready & hs_we);
  assign wr_addr = lp_write ? lp_addr : hs_addr;
  // order tracking; ff marks nothing seen since reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      last_wr <= 8'hFF;
      last_rd <= 8'hFF;
    end else begin
      if (wr_ev) last_wr <= wr_addr;
      if (lp_read) last_rd <= lp_addr;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_num_after_ctl: assert property (wr_ev && wr_addr == OFS_NUMERATOR |-> last_wr == OFS_CONTROL)
    else $error("numerator written without control first");
  a_div_after_num: assert property (wr_ev && wr_addr == OFS_DIVISOR |-> last_wr == OFS_NUMERATOR)
    else $error("divisor written without numerator first");
  a_root_after_ctl: assert property (wr_ev && wr_addr == OFS_ROOT |-> last_wr == OFS_CONTROL)
    else $error("root operand written without control first");
  a_poll_before_read: assert property (lp_read && lp_addr == OFS_RESULT |-> last_rd == OFS_STATUS)
    else $error("local result read without busy poll");
  a_ready_pulse: assert property (hs_ready |=> !hs_ready)
    else $error("ready longer than one cycle");
  a_req_held: assert property (hs_req && !hs_ready |=> hs_req && $stable(hs_addr) && $stable(hs_we))
    else $error("fast request changed before ready");
  a_req_drop: assert property (hs_ready |=> !hs_req)
    else $error("fast request not dropped after ready");
  a_fast_bounded: assert property ($rose(hs_req) |-> ##[1:20] hs_ready)
    else $error("fast request never answered");
  a_rdata_hold: assert property (!hs_ready |-> $stable(hs_rdata))
    else $error("fast read data moved without ready");
  a_local_single: assert property (!(lp_read && lp_write))
    else $error("local read and write together");
endmodule : accel_monitor

// ### tb/div_sqrt_accelerator_tb.sv
`timescale 1ns/1ps
module div_sqrt_accelerator_tb;
  import accel_pkg::*;
  // one job: setup, operands, expected results
  typedef struct {
    logic [7:0]  setup;
    logic [31:0] a, b, q, r;
    logic        zf;
  } job_s;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  cmd_addr = 8'h00;
  logic [31:0] cmd_wdata = 32'h0;
  logic        cmd_write = 1'b0;
  logic        cmd_read = 1'b0;
  logic [31:0] cmd_rdata;
  logic        clk_req;
  int          n_errors = 0;
  int          check_count = 0;
  int          dur [13];
  logic [31:0] v, q, r;
  // zero divide rows last: the flag sticks from there on
  job_s rows [13] = '{
    '{8'h10, 32'd100, 32'd7, 32'd14, 32'd2, 1'b0},
    '{8'h16, 32'd100, 32'd7, 32'd14, 32'd2, 1'b0},
    '{8'h16, 32'h10000, 32'd7, 32'h2492, 32'd2, 1'b0},
    '{8'h14, 32'd1, 32'd1, 32'd1, 32'd0, 1'b0},
    '{8'h11, 32'hFFFFFF9C, 32'd7, 32'hFFFFFFF2, 32'hFFFFFFFE, 1'b0},
    '{8'h15, 32'd100, 32'hFFFFFFF9, 32'hFFFFFFF2, 32'd2, 1'b0},
    '{8'h11, 32'h80000000, 32'hFFFFFFFF, 32'h80000000, 32'd0, 1'b0},
    '{8'h15, 32'hFFFF8000, 32'hFFFFFFFF, 32'hFFFF8000, 32'd0, 1'b0},
    '{8'h10, 32'hFFFFFFFF, 32'h10000, 32'hFFFF, 32'hFFFF, 1'b0},
    '{8'h18, 32'd1000, 32'd1000, 32'd31, 32'd39, 1'b0},
    '{8'h1C, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFF, 32'h1FFFE, 1'b0},
    '{8'h10, 32'd1234, 32'd0, 32'd0, 32'd1234, 1'b1},
    '{8'h15, 32'hFFFFFFFB, 32'd0, 32'd0, 32'hFFFFFFFB, 1'b1}
  };
  // ****************************************
  // design and watcher
  // ****************************************
  accel_if u_accel_if ();
  div_root_engine u_div_root_engine (.sys_clk(sys_clk), .rst(rst), .bus(u_accel_if));
  accel_master u_accel_master (.sys_clk(sys_clk), .rst(rst), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_rdata(cmd_rdata), .clk_req(clk_req), .bus(u_accel_if));
  accel_monitor u_accel_monitor (.sys_clk(sys_clk), .rst(rst),
    .hs_req(u_accel_if.hs_req), .hs_we(u_accel_if.hs_we), .hs_addr(u_accel_if.hs_addr),
    .hs_wdata(u_accel_if.hs_wdata), .hs_ready(u_accel_if.hs_ready), .hs_rdata(u_accel_if.hs_rdata),
    .lp_write(u_accel_if.lp_write), .lp_read(u_accel_if.lp_read), .lp_addr(u_accel_if.lp_addr),
    .lp_wdata(u_accel_if.lp_wdata), .lp_rdata(u_accel_if.lp_rdata));
  // 40 MHz
  always #12.5 sys_clk = ~sys_clk;
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cmd_write <= 1'b1;
    cmd_addr  <= a;
    cmd_wdata <= d;
    @(posedge sys_clk);
    cmd_write <= 1'b0;
  endtask : wr
  // data stands from the cycle after the strobe until the next read strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    cmd_read <= 1'b1;
    cmd_addr <= a;
    @(posedge sys_clk);
    cmd_read <= 1'b0;
    #1 d = cmd_rdata;
  endtask : rd
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // polls in two-cycle steps; equal overhead per job, so differences are exact
  task automatic run_job(input job_s j, output int cyc);
    logic [31:0] s;
    wr(CMD_SETUP, {24'h0, j.setup});
    wr(CMD_OPA, j.a);
    wr(CMD_OPB, j.b);
    wr(CMD_GO, 32'h0);
    cyc = 0;
    s = 32'h1;
    while (s[0] !== 1'b0 || s[1] !== 1'b1) begin
      rd(CMD_STATUS, s);
      cyc += 2;
      if (cyc > 600) begin
        n_errors++;
        $display("CHECK FAILED t=%0t job never finished", $time);
        return;
      end
    end
    rd(CMD_RESULT, q);
    rd(CMD_REMAIN, r);
    rd(CMD_STATUS, v);
  endtask : run_job
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd(CMD_STATUS, v);
    chk(v, 32'h0); // RESET
    rd(CMD_RESULT, v);
    chk(v, 32'h0); // RESET
    // no job without the engine clock
    wr(CMD_SETUP, 32'h0);
    wr(CMD_GO, 32'h0);
    rd(CMD_STATUS, v);
    chk(v, 32'h0);
    chk({31'h0, clk_req}, 32'h0);
    wr(CMD_SETUP, 32'h10);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, clk_req}, 32'h1);
    rd(CMD_SETUP, v);
    chk(v, 32'h10);
    $display("test reset and clock gate done");
    // table of ordinary jobs
    for (int i = 0; i < 13; i++) begin
      run_job(rows[i], dur[i]);
      chk(q, rows[i].q);
      chk(r, rows[i].r);
      chk({31'h0, v[2]}, {31'h0, rows[i].zf});
      $display("test row %0d done", i);
    end
    // fixed latency, skip off: 16 vs 8 cycles
    chk(dur[2] - dur[1], 32'd8);
    // skip on (setup bit 1 clear): 1/1 takes the 2-cycle minimum
    chk(dur[1] - dur[3], 32'd6);
    // reset in mid-run clears the sticky flag and aborts the job
    wr(CMD_SETUP, 32'h10);
    wr(CMD_OPA, 32'hFFFFFFFF);
    wr(CMD_OPB, 32'd3);
    wr(CMD_GO, 32'h0);
    repeat (4) @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    rd(CMD_STATUS, v);
    chk(v, 32'h0); // RESET
    run_job(rows[0], dur[0]);
    chk(q, 32'd14);
    chk({31'h0, v[2]}, 32'h0);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule : div_sqrt_accelerator_tb
